// ### logic/jtl_pkg.sv
// Package of constants and types for the transmit link layer
package jtl_pkg;
   // ***************************************************************
   // Octet and code-group widths
   // ***************************************************************
   localparam int unsigned OCTET_W = 8;      // Octet width
   localparam int unsigned CODE_W  = 10;     // Code-group width
   localparam int unsigned SAMP_W  = 14;     // Converter sample width
   localparam int unsigned LANES   = 2;      // Serial output lanes

   // ***************************************************************
   // Control characters (K28.y octet values)
   // ***************************************************************
   localparam logic [7:0] K28_5_OCTET = 8'hBC;  // Sync comma
   localparam logic [7:0] K28_7_OCTET = 8'hFC;  // Frame marker
   localparam logic [7:0] K28_3_OCTET = 8'h7C;  // Multiframe marker

   // ***************************************************************
   // Frame and multiframe structure
   // ***************************************************************
   localparam logic [4:0] FRAMES_PER_MF_M1 = 5'h1F;  // 32 frames, the maximum
   localparam logic [4:0] MF_LAST_RESET    = 5'h1F;  // Multiframe count after reset

   // ***************************************************************
   // Scrambler
   // ***************************************************************
   localparam logic [14:0] SCR_SEED = 15'h7F80;  // Scrambler state after reset
   localparam logic        RD_RESET = 1'b0;      // Running disparity: negative

   // Link states, one-hot
   typedef enum logic [2:0] {
      JTL_SYNC  = 3'b001,   // Sending K28.5 while sync requested
      JTL_WAIT  = 3'b010,   // Sync released, waiting for multiframe boundary
      JTL_DATA  = 3'b100    // Sending scrambled frames
   } jtl_state_e;
endpackage : jtl_pkg

// ### logic/jtl_tx_link.sv
// Transmit link layer: packing, scrambling, marker insertion, 8b/10b encoding
// ***************************************************************
// Module
// ***************************************************************
// How it works
// - Every octet leaves as an 8b/10b code-group
// - All 256 data and twelve K codes
// - Comma codes are K28.1, K28.5, K28.7
// - Scramble octets with 1+x^14+x^15
// - Frame is two code-groups, one sample
// - K28.7 replaces frame end when repeating
// - Only K28.5 while sync request low
// - First data code starts a frame
// - K28.3 replaces multiframe end when repeating
// - Multiframe clock generated internally
// - Multiframe never longer than 32 frames
// - Encoding picked by running disparity
// - Disparity judged per six and four bits
// - Lanes carry up to 6.0 Gbps
// - Overrange flags in stream and side output
// - Both channels taken in one cycle
// - Fixed pipeline delay after every sync
// - Overflow bit follows sample LSB
// - Samples are offset binary
// - One lane carries both, or one each
module jtl_tx_link
   import jtl_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                arst_n,
   // Converter sample input, both channels on one cycle
   input  wire logic [SAMP_W-1:0]   sample_a,
   input  wire logic [SAMP_W-1:0]   sample_b,
   input  wire logic                overrange_flag_a,
   input  wire logic                overrange_flag_b,
   input  wire logic                sample_valid,
   output logic                     sample_ready,
   // Configuration levels
   input  wire logic                single_lane,
   input  wire logic                scramble_en,
   // Link sync request from the receiver, a pin
   input  wire logic                sync_n,
   // Code-group outputs, one per lane, to the serialiser
   output logic [CODE_W-1:0]        lane0_code,
   output logic [CODE_W-1:0]        lane1_code,
   output logic                     code_valid,
   input  wire logic                code_ready,
   // Early overrange indication, A then B
   output logic                     overrange_out
);
   // ***************************************************************
   // 8b/10b encoder, bits abcdei fghj with a sent first
   // ***************************************************************
   function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
                                            input logic rd);
      logic [5:0] s6;
      logic [3:0] s4;
      logic       rd1;
      logic       alt;
      logic [4:0] x;
      logic [2:0] y;
      int         n;
      x = d[4:0];
      y = d[7:5];
      s6 = 6'h00;
      s4 = 4'h0;
      // Six-bit table for negative disparity (abcdei)
      case (x)
         5'd0: s6 = 6'b100111;  5'd1: s6 = 6'b011101;  5'd2: s6 = 6'b101101;
         5'd3: s6 = 6'b110001;  5'd4: s6 = 6'b110101;  5'd5: s6 = 6'b101001;
         5'd6: s6 = 6'b011001;  5'd7: s6 = 6'b111000;  5'd8: s6 = 6'b111001;
         5'd9: s6 = 6'b100101;  5'd10: s6 = 6'b010101; 5'd11: s6 = 6'b110100;
         5'd12: s6 = 6'b001101; 5'd13: s6 = 6'b101100; 5'd14: s6 = 6'b011100;
         5'd15: s6 = 6'b010111; 5'd16: s6 = 6'b011011; 5'd17: s6 = 6'b100011;
         5'd18: s6 = 6'b010011; 5'd19: s6 = 6'b110010; 5'd20: s6 = 6'b001011;
         5'd21: s6 = 6'b101010; 5'd22: s6 = 6'b011010; 5'd23: s6 = 6'b111010;
         5'd24: s6 = 6'b110011; 5'd25: s6 = 6'b100110; 5'd26: s6 = 6'b010110;
         5'd27: s6 = 6'b110110; 5'd28: s6 = 6'b001110; 5'd29: s6 = 6'b101110;
         5'd30: s6 = 6'b011110; default: s6 = 6'b101011;
      endcase
      if (k && x == 5'd28) begin
         s6 = 6'b001111;      // K28 carries the comma run
      end
      // Unbalanced or D.07 blocks invert on positive disparity
      n = $countones(s6);
      if (rd && (n != 3 || x == 5'd7)) begin
         s6 = ~s6;
      end
      rd1 = (n != 3) ? ~rd : rd;
      // Four-bit table for negative disparity (fghj)
      alt = (!rd1 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
            || (rd1 && (x == 5'd11 || x == 5'd13 || x == 5'd14)) || k;
      case (y)
         3'd0: s4 = 4'b1011;  3'd1: s4 = 4'b1001;  3'd2: s4 = 4'b0101;
         3'd3: s4 = 4'b1100;  3'd4: s4 = 4'b1101;  3'd5: s4 = 4'b1010;
         3'd6: s4 = 4'b0110;  default: s4 = alt ? 4'b0111 : 4'b1110;
      endcase
      // K28 balanced sub-blocks flip only after a negative six-bit run
      if (k && !rd1 && (y == 3'd1 || y == 3'd2 || y == 3'd5 || y == 3'd6)) begin
         s4 = ~s4;
      end
      n = $countones(s4);
      if (rd1 && (n != 2 || y == 3'd3)) begin
         s4 = ~s4;
      end
      rd1 = (n != 2) ? ~rd1 : rd1;
      return {rd1, s6, s4};
   endfunction

   // Three-stage pin synchroniser for sync request
   logic [2:0]    sync_pipe;   // Stage 0 is read by stage 1 only
   logic          sync_req;    // Filtered sync request, high = requested
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync_pipe <= 3'b000;
         sync_req  <= 1'b1;
      end else begin
         sync_pipe <= {sync_pipe[1:0], sync_n};
         // Change counts once stages 1 and 2 agree
         if (sync_pipe[1] == sync_pipe[2]) begin
            sync_req <= ~sync_pipe[2];
         end
      end
   end

   // ***************************************************************
   // Two-entry input buffer, holds both channels captured together
   // ***************************************************************
   localparam int unsigned BUF_W = 2 * (SAMP_W + 1);
   logic [BUF_W-1:0] buf_mem [2];  // Entries
   logic             wr_ptr;       // Write slot
   logic             rd_ptr;       // Read slot
   logic [1:0]       buf_cnt;      // Filled entries
   logic             buf_take;     // Drain one entry
   logic             buf_put;      // Fill one entry
   logic [BUF_W-1:0] head;         // Oldest entry

   assign buf_put = sample_valid && sample_ready;
   assign head    = buf_mem[rd_ptr];

   // Storage and pointers; ready is a flop so back-pressure is honest
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr       <= 1'b0;
         rd_ptr       <= 1'b0;
         buf_cnt      <= 2'd0;
         sample_ready <= 1'b0;
         buf_mem[0]   <= '0;
         buf_mem[1]   <= '0;
      end else begin
         if (buf_put) begin
            // both channels of one instant, flag after LSB
            buf_mem[wr_ptr] <= {sample_a, overrange_flag_a, sample_b, overrange_flag_b};
            wr_ptr          <= ~wr_ptr;
         end
         if (buf_take) begin
            rd_ptr <= ~rd_ptr;
         end
         buf_cnt      <= buf_cnt + 2'(buf_put) - 2'(buf_take);
         sample_ready <= (buf_cnt + 2'(buf_put) - 2'(buf_take)) < 2'd2;
      end
   end

   // Side overrange output, channel A then channel B
   logic of_phase;  // Half select
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         of_phase      <= 1'b0;
         overrange_out <= 1'b0;
      end else begin
         of_phase      <= ~of_phase;
         overrange_out <= of_phase ? overrange_flag_b : overrange_flag_a;
      end
   end

   // ***************************************************************
   // Frame sequencing and local multiframe clock
   // ***************************************************************
   jtl_state_e state;      // Link state
   logic       oct_idx;    // Octet within frame (0 first)
   logic [4:0] frame_idx;  // Frame within multiframe
   logic       step;       // One code-group per lane leaves
   logic [2*(SAMP_W+1)-1:0] cur;  // Sample being sent
   logic       cur_half;   // Single lane: 0 sends channel A frame, 1 channel B

   assign step     = !code_valid || code_ready;
   // One sample drains per single-lane half frame pair or per two-lane frame
   assign buf_take = step && state == JTL_DATA && oct_idx == 1'b1
                     && buf_cnt != 2'd0 && !(single_lane && cur_half == 1'b0);

   // Octet counter advances on every step; frame and half counters at each frame end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         oct_idx   <= 1'b0;
         frame_idx <= MF_LAST_RESET;
         cur_half  <= 1'b0;
      end else if (step) begin
         // counters free-run from reset, fixing delay
         oct_idx <= ~oct_idx;
         if (oct_idx) begin
            frame_idx <= (frame_idx == FRAMES_PER_MF_M1) ? 5'd0 : frame_idx + 5'd1;
            cur_half  <= single_lane ? ~cur_half : 1'b0;
         end
      end
   end

   // Link state machine
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= JTL_SYNC;
      end else if (sync_req) begin
         state <= JTL_SYNC;
      end else if (step) begin
         case (state)
            JTL_SYNC: state <= JTL_WAIT;
            // Data begins at the next multiframe boundary
            JTL_WAIT: if (oct_idx && frame_idx == FRAMES_PER_MF_M1) state <= JTL_DATA;
            JTL_DATA: state <= JTL_DATA;
            default:  state <= JTL_SYNC;
         endcase
      end
   end

   // ***************************************************************
   // Octet selection, scrambling, markers, encoding per lane
   // ***************************************************************
   logic [BUF_W-1:0] cur_next;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else if (step && oct_idx == 1'b1) begin
         cur <= cur_next;
      end
   end
   assign cur_next = (buf_take || (single_lane && cur_half == 1'b0))
                     ? (buf_take ? head : cur) : cur;

   // sample, flag, filler zero, MSB first into two octets
   logic [15:0] word_a;
   logic [15:0] word_b;
   assign word_a = {cur[29:16], cur[15], 1'b0};
   assign word_b = {cur[14:1], cur[0], 1'b0};

   logic [14:0] scr      [LANES];  // Scrambler state per lane
   logic        rd       [LANES];  // Running disparity per lane
   logic [7:0]  last_oct [LANES];  // Last frame-end octet per lane, before marker swap
   logic [10:0] enc      [LANES];
   logic [7:0]  plain    [LANES];
   logic [7:0]  sc       [LANES];
   logic        is_k     [LANES];
   logic [7:0]  oct      [LANES];

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [15:0] word;
      logic [14:0] s;
      // lane 0 alternates channels in single-lane mode
      assign word = (l == 0) ? ((single_lane && cur_half) ? word_b : word_a) : word_b;
      assign plain[l] = oct_idx ? word[7:0] : word[15:8];

      // self-synchronising, feedback from sent bits, MSB first
      always_comb begin
         s = scr[l];
         for (int i = 7; i >= 0; i--) begin
            sc[l][i] = plain[l][i] ^ (scramble_en ? (s[13] ^ s[14]) : 1'b0);
            s        = {s[13:0], sc[l][i]};
         end
      end

      // Marker substitution on repeat of the last octet
      always_comb begin
         is_k[l] = 1'b0;
         oct[l]  = sc[l];
         if (state != JTL_DATA) begin
            is_k[l] = 1'b1;
            oct[l]  = K28_5_OCTET;
         end else if (oct_idx && sc[l] == last_oct[l]) begin
            is_k[l] = 1'b1;
            oct[l]  = (frame_idx == FRAMES_PER_MF_M1) ? K28_3_OCTET
                                                      : K28_7_OCTET;
         end
      end
      assign enc[l] = enc8b10b(oct[l], is_k[l], rd[l]);

      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            scr[l]      <= SCR_SEED;
            rd[l]       <= RD_RESET;
            last_oct[l] <= 8'h00;
         end else if (step) begin
            rd[l] <= enc[l][10];
            if (state == JTL_DATA) begin
               scr[l] <= s;
               if (oct_idx) last_oct[l] <= sc[l];
            end
         end
      end
   end

   // Output registers; both lanes load on every step, lane 1 also in single-lane mode
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lane0_code <= '0;
         lane1_code <= '0;
         code_valid <= 1'b0;
      end else if (step) begin
         lane0_code <= enc[0][9:0];
         lane1_code <= enc[1][9:0];
         code_valid <= 1'b1;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   // State follows the filtered request one edge later
   chk_sync_comma: assert property (@(posedge clock) disable iff (!arst_n)
      sync_req |=> state == JTL_SYNC) else $error("sync request not honoured");
   chk_data_start: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(state == JTL_DATA) |-> oct_idx == 1'b0) else $error("data off frame edge");
   chk_mf_bound: assert property (@(posedge clock) disable iff (!arst_n)
      frame_idx <= FRAMES_PER_MF_M1) else $error("multiframe too long");
   chk_frame_two: assert property (@(posedge clock) disable iff (!arst_n)
      step |=> oct_idx != $past(oct_idx)) else $error("frame not two codes");
   chk_buf_full: assert property (@(posedge clock) disable iff (!arst_n)
      buf_cnt == 2'd2 |-> !sample_ready) else $error("ready while full");
   chk_k_marker: assert property (@(posedge clock) disable iff (!arst_n)
      state == JTL_DATA && is_k[0] |-> oct_idx) else $error("marker off frame end");
   chk_mf_marker: assert property (@(posedge clock) disable iff (!arst_n)
      oct[0] == K28_3_OCTET && is_k[0] |-> frame_idx == FRAMES_PER_MF_M1)
      else $error("K28.3 off multiframe end");
   chk_disparity: assert property (@(posedge clock) disable iff (!arst_n)
      step |=> rd[0] == ($past(rd[0]) ^ (($countones(lane0_code) != 5))))
      else $error("disparity tracking wrong");
   chk_comma_out: assert property (@(posedge clock) disable iff (!arst_n)
      state == JTL_SYNC && step
      |=> (lane0_code[9:4] == 6'b001111 || lane0_code[9:4] == 6'b110000))
      else $error("comma missing while syncing");
endmodule // jtl_tx_link

// ### sim/jtl_rx_model.sv
// Receiver-side model: sync request, serialiser stalls, disparity watch
module jtl_rx_model
   import jtl_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // Bench controls
   input  wire logic              req_sync,
   input  wire logic              stall,
   // Code-groups from the link
   input  wire logic [CODE_W-1:0] lane0_code,
   input  wire logic [CODE_W-1:0] lane1_code,
   input  wire logic              code_valid,
   // Back to the link
   output logic                   sync_n,
   output logic                   code_ready,
   output logic [9:0]             err_count
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] rd_pos;   // Running disparity per lane, high when positive

   // Sync request is active low on the pin
   assign sync_n     = ~req_sync;
   // Stall holds every code-group in place
   assign code_ready = ~stall;

   // ***************************************************************
   // Disparity tracking on every code-group taken
   // ***************************************************************
   // Six ones only from negative, four only from positive
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_pos    <= {2{RD_RESET}};
         err_count <= 10'h000;
      end else if (code_valid && code_ready) begin
         for (int l = 0; l < 2; l++) begin
            automatic int n = $countones(l == 0 ? lane0_code : lane1_code);
            if ((n == 6 && rd_pos[l]) || (n == 4 && !rd_pos[l]) || n < 4 || n > 6) begin
               err_count <= err_count + 10'h001;
            end
            if (n == 6) rd_pos[l] <= 1'b1;
            if (n == 4) rd_pos[l] <= 1'b0;
         end
      end
   end
endmodule // jtl_rx_model

// ### sim/testbench.sv
// Self-checking bench for the transmit link layer
module testbench;
   import jtl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ***************************************************************
   // Signals
   // ***************************************************************
   logic              clock = 1'b0;
   logic              arst_n = 1'b0;
   logic [SAMP_W-1:0] sample_a = 14'h2000;
   logic [SAMP_W-1:0] sample_b = 14'h1FFF;
   logic              overrange_flag_a = 1'b0;
   logic              overrange_flag_b = 1'b0;
   logic              sample_valid = 1'b1;
   logic              sample_ready;
   logic              single_lane = 1'b0;
   logic              scramble_en = 1'b0;
   logic              sync_n, code_valid, code_ready, overrange_out;
   logic [CODE_W-1:0] lane0_code, lane1_code;
   logic              req_sync = 1'b1;
   logic              stall = 1'b0;
   logic [9:0]        err_count;
   int                bad_count = 0;
   int                n_compared = 0;

   // 25 MHz clock
   always #20 clock = ~clock;

   jtl_tx_link jtl_tx_link_inst (.clock(clock), .arst_n(arst_n), .sample_a(sample_a),
      .sample_b(sample_b), .overrange_flag_a(overrange_flag_a),
      .overrange_flag_b(overrange_flag_b), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .single_lane(single_lane), .scramble_en(scramble_en),
      .sync_n(sync_n), .lane0_code(lane0_code), .lane1_code(lane1_code),
      .code_valid(code_valid), .code_ready(code_ready), .overrange_out(overrange_out));

   jtl_rx_model jtl_rx_model_inst (.clock(clock), .arst_n(arst_n), .req_sync(req_sync),
      .stall(stall), .lane0_code(lane0_code), .lane1_code(lane1_code),
      .code_valid(code_valid), .sync_n(sync_n), .code_ready(code_ready),
      .err_count(err_count));

   // ***************************************************************
   // Compare and helper tasks
   // ***************************************************************
   task automatic cmp_kind(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic cmp_code(input string what, input logic [9:0] exp, input logic [9:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Kind of code: 0 data, 1 sync comma, 2 frame marker, 3 multiframe marker
   function automatic logic [1:0] kind_of(input logic [9:0] c);
      if (c === 10'h0FA || c === 10'h305) return 2'd1;
      if (c === 10'h0F8 || c === 10'h307) return 2'd2;
      if (c === 10'h0F3 || c === 10'h30C) return 2'd3;
      return 2'd0;
   endfunction

   // Next code-group pair taken, read at the settled falling edge
   task automatic next_code(output logic [9:0] c0, output logic [9:0] c1);
      for (int i = 0; i < 20; i++) begin
         @(negedge clock);
         if (code_valid === 1'b1 && code_ready === 1'b1) break;
      end
      c0 = lane0_code;
      c1 = lane1_code;
   endtask

   // Reset with the static mode levels applied
   task automatic do_reset(input logic single, input logic scr);
      @(posedge clock);
      #1;
      arst_n      = 1'b0;
      req_sync    = 1'b1;
      single_lane = single;
      scramble_en = scr;
      repeat (10) @(posedge clock);
      #1;
      arst_n = 1'b1;
   endtask

   // Only commas on both lanes while sync is held, then release
   task automatic t_sync_hold();
      logic [9:0] c0, c1;
      repeat (6) next_code(c0, c1);
      for (int i = 0; i < 16; i++) begin
         next_code(c0, c1);
         cmp_kind("lane0 comma", 2'd1, kind_of(c0));
         cmp_kind("lane1 comma", 2'd1, kind_of(c1));
      end
      @(posedge clock);
      #1;
      req_sync = 1'b0;
   endtask

   // Comma end, frame and multiframe marker positions, or a marker bound
   task automatic t_link(input bit exact, input int max_mk);
      logic [9:0] c0, c1;
      logic [1:0] exp;
      int         n, mk;
      n  = 0;
      mk = 0;
      next_code(c0, c1);
      while (kind_of(c0) == 2'd1 && n < 300) begin
         n++;
         next_code(c0, c1);
      end
      cmp_kind("first data code", 2'd0, kind_of(c0));
      for (int i = 1; i < 128; i++) begin
         next_code(c0, c1);
         // Frame ends become markers since the samples never change
         exp = (i % 2 == 0) ? 2'd0 : ((i % 64 == 63) ? 2'd3 : 2'd2);
         // First frame still carries the sample held before data began, second frame end compares with it
         if (exact && i > 3) begin
            cmp_kind("lane0 code kind", exp, kind_of(c0));
            cmp_kind("lane1 code kind", exp, kind_of(c1));
         end else if (!exact && i > 3 && kind_of(c0) != 2'd0) begin
            mk++;
         end
      end
      if (!exact) cmp_kind("marker bound", 2'd1, {1'b0, mk <= max_mk});
   endtask

   // Stall holds codes and fills the two-entry buffer
   task automatic t_stall();
      logic [9:0] held;
      @(posedge clock);
      #1;
      stall = 1'b1;
      held  = lane0_code;
      repeat (8) @(negedge clock);
      cmp_code("code held in stall", held, lane0_code);
      cmp_kind("buffer refuses", 2'd0, {1'b0, sample_ready});
      @(posedge clock);
      #1;
      stall = 1'b0;
      for (int i = 0; i < 10 && sample_ready !== 1'b1; i++) @(negedge clock);
      cmp_kind("buffer drains", 2'd1, {1'b0, sample_ready});
   endtask

   // Early overrange output alternates A then B
   task automatic t_overrange();
      logic prev;
      @(posedge clock);
      #1;
      overrange_flag_a = 1'b1;
      repeat (12) @(negedge clock);
      prev = overrange_out;
      for (int i = 0; i < 6; i++) begin
         @(negedge clock);
         cmp_kind("overrange toggles", {1'b0, ~prev}, {1'b0, overrange_out});
         prev = overrange_out;
      end
      @(posedge clock);
      #1;
      overrange_flag_a = 1'b0;
      repeat (12) @(negedge clock);
      cmp_kind("overrange idle", 2'd0, {1'b0, overrange_out});
   endtask

   // ***************************************************************
   // Verdict and main sequence
   // ***************************************************************
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well beyond the expected run
   initial begin
      #(40 * 40000);
      bad_count++;
      test_done();
   end

   initial begin
      do_reset(1'b0, 1'b0);
      t_sync_hold();
      t_link(1'b1, 0);
      t_stall();
      t_overrange();
      // Second sync request in mid-run restarts alignment
      @(posedge clock);
      #1;
      req_sync = 1'b1;
      t_sync_hold();
      t_link(1'b1, 0);
      // One lane carrying alternating A and B frames
      do_reset(1'b1, 1'b0);
      t_sync_hold();
      t_link(1'b0, 0);
      // Scrambled constant input rarely repeats a frame end
      do_reset(1'b0, 1'b1);
      t_sync_hold();
      t_link(1'b0, 8);
      cmp_code("disparity errors", 10'h000, err_count);
      test_done();
   end
endmodule // testbench
